// ---- kite_asserts.sv ----
`timescale 1ns/1ps
module kite_chk (
  // clock and reset
  input wire        clock,
  input wire        reset_n,
  // keypad and logging
  input wire        key_down,
  input wire [3:0]  key_code,
  input wire        log_enable,
  // front end
  input wire        meas_req_q,
  input wire [3:0]  meas_chan_q,
  input wire [7:0]  meas_prog_q,
  // display and scan
  input wire [7:0]  disp_id_q,
  input wire [15:0] disp_data_q,
  input wire        disp_blank_q,
  input wire        disp_colon_q,
  input wire        scan_done_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_star;
    $rose(key_down) && key_code == 4'he;
  endsequence
  sequence s_prompt;
    ##[2:12] (disp_id_q == 8'h00 && disp_data_q == 16'h0000 && !disp_blank_q);
  endsequence
  sequence s_log_off;
    !log_enable [*8];
  endsequence
  chk_star_prompt: assert property (s_star |-> s_prompt)
    else $error("star key did not restore the idle prompt");
  chk_colon_lit: assert property (disp_colon_q)
    else $error("colon separator dark");
  chk_disp_cap: assert property (!disp_blank_q |-> disp_data_q[15:12] <= 4'h6)
    else $error("display magnitude above 6999");
  chk_skip_unused: assert property (meas_req_q |-> meas_chan_q == 4'h0 || meas_prog_q != 8'h00)
    else $error("request issued for an unused channel");
  chk_batt_prog: assert property (meas_req_q && meas_chan_q == 4'h0 |-> meas_prog_q == 8'h00)
    else $error("battery request carries a program");
  chk_cnt_noreq: assert property (meas_req_q |-> meas_chan_q <= 4'h7)
    else $error("analog request for a counter channel");
  chk_req_pulse: assert property (meas_req_q |=> !meas_req_q)
    else $error("request longer than one cycle");
  chk_chan_hold: assert property (!meas_req_q |-> $stable(meas_chan_q))
    else $error("channel moved without a request");
  chk_scan_gate: assert property (s_log_off |-> !scan_done_q)
    else $error("scan finished with logging off");
  chk_scan_pulse: assert property (scan_done_q |=> !scan_done_q)
    else $error("scan done longer than one cycle");
endmodule
bind kite_core kite_chk u_chk (.clock(clock), .reset_n(reset_n), .key_down(key_down),
  .key_code(key_code), .log_enable(log_enable), .meas_req_q(meas_req_q),
  .meas_chan_q(meas_chan_q), .meas_prog_q(meas_prog_q), .disp_id_q(disp_id_q),
  .disp_data_q(disp_data_q), .disp_blank_q(disp_blank_q), .disp_colon_q(disp_colon_q),
  .scan_done_q(scan_done_q));

// ---- kite_consts.vh ----
`ifndef KITE_CONSTS_VH
`define KITE_CONSTS_VH

// clock and timing
`define KITE_CLK_HZ          40000000
`define KITE_SCAN_PERIOD_S   60
`define KITE_MON_PERIOD_MS   1000
// scan and refresh periods in clock cycles at 40 MHz
`define KITE_SCAN_CYCLES     32'd2400000000
`define KITE_MON_CYCLES      32'd40000000

// fixed point: every value is held in units of 1/10000
`define KITE_FIX_ONE         32'sd10000
`define KITE_FIX_DIGITS      4
`define KITE_VAL_MAX         32'sd69990000
`define KITE_DISP_MAX        32'd6999
`define KITE_MULT_DIGITS     3'd4

// channels and table layout
`define KITE_CH_FIRST        4'h1
`define KITE_CH_LAST         4'h9
`define KITE_CH_BATT         4'h0
`define KITE_CH_PULSE_A      4'h8
`define KITE_CH_PULSE_B      4'h9
`define KITE_ENT_PROG        2'h1
`define KITE_ENT_MULT        2'h2
`define KITE_ENT_OFFS        2'h3
`define KITE_CNT_A_MAX       12'hfff
`define KITE_CNT_B_MAX       4'hf

// key codes
`define KITE_KEY_ADV         4'ha
`define KITE_KEY_REST        4'hb
`define KITE_KEY_NEG         4'hc
`define KITE_KEY_DP          4'hd
`define KITE_KEY_STAR        4'he
`define KITE_KEY_CLR         4'hf

// mode digits
`define KITE_MODE_TABLE      4'h4
`define KITE_MODE_MON        4'h6

// reset values
`define KITE_MULT_RST        32'sd10000
`define KITE_ZERO32          32'h0000_0000

`endif

// ---- kite_core.v ----
// Operation
// - digits enter numbers, star starts mode selection, advance steps, stores or runs
// - B restarts mode, C negates entry, D inserts point, # clears entry
// - three entries per channel; identifier shows channel then entry index
// - program number zero marks channel unused and it is not measured
// - reading equals raw input times multiplier plus offset
// - advance with no digit in table mode points at channel 1 entry 1
// - channel digit before advance jumps to entry 1 of that channel
// - multiplier kept at four decimals, shown with at most three
// - at most four significant multiplier digits; outputs clamped to 6999 magnitude
// - monitor: digit then advance selects channel 0-9; 0 is battery
// - monitor shows selected value within one to three seconds
// - monitor identifier shows channel, colon, then scaled value
// - in monitor a lone digit switches channel without advance
// - star leaves mode and shows zero prompt
// - pulse channels 8 and 9 cleared at every scan
// - uncleared pulse counters saturate at 4095 and 15
// - magnitudes above 6999 shown with one fewer significant digit
// - scaling arithmetic keeps full internal precision regardless of display
// - star, prompt, then mode digit; mode digit shown in identifier
// - channels 1-9 read and scaled once per scan interval while logging is enabled; battery channel 0 not scanned
`timescale 1ns/1ps
`include "kite_consts.vh"
module kite_core #(
  parameter [31:0] SCAN_CYCLES = `KITE_SCAN_CYCLES,
  parameter [31:0] MON_CYCLES  = `KITE_MON_CYCLES
) (
  // clock and reset
  input  wire        clock,
  input  wire        reset_n,
  // keypad pins
  input  wire        key_down,
  input  wire [3:0]  key_code,
  // logging enable and pulse inputs (pins)
  input  wire        log_enable,
  input  wire        pulse_a,
  input  wire        pulse_b,
  // measurement front end, same clock
  output reg         meas_req_q,
  output reg  [3:0]  meas_chan_q,
  output reg  [7:0]  meas_prog_q,
  input  wire        meas_valid,
  input  wire [31:0] meas_raw_input_units,
  // six digit display
  output reg  [7:0]  disp_id_q,
  output reg  [15:0] disp_data_q,
  output reg  [1:0]  disp_point_q,
  output reg         disp_neg_q,
  output reg         disp_blank_q,
  output reg         disp_colon_q,
  // scan done strobe, one cycle at the end of each scan; results stay internal
  output reg         scan_done_q
);

  localparam [1:0] U_PROMPT = 2'h0;
  localparam [1:0] U_OTHER  = 2'h1;
  localparam [1:0] U_TABLE  = 2'h2;
  localparam [1:0] U_MON    = 2'h3;
  localparam [1:0] S_IDLE   = 2'h0;
  localparam [1:0] S_WAIT   = 2'h1;

  function [31:0] pow10;
    input [2:0] n;
    begin
      case (n)
        3'h0:    pow10 = 32'h0000_0001;
        3'h1:    pow10 = 32'h0000_000a;
        3'h2:    pow10 = 32'h0000_0064;
        3'h3:    pow10 = 32'h0000_03e8;
        default: pow10 = 32'h0000_2710;
      endcase
    end
  endfunction

  // product kept at 64 bits so no precision is lost before the clamp
  function signed [31:0] scale;
    input signed [31:0] m;
    input signed [31:0] b;
    input signed [31:0] x;
    reg   signed [63:0] p;
    begin
      p = m * x;
      p = p / 64'sd10000 + b;
      if (p > 64'sd69990000)
        scale = `KITE_VAL_MAX;
      else if (p < -64'sd69990000)
        scale = -`KITE_VAL_MAX;
      else
        scale = p[31:0];
    end
  endfunction

  function [15:0] to_bcd;
    input [12:0] bin;
    reg   [28:0] sh;
    integer i;
    begin
      sh = {16'h0000, bin};
      for (i = 0; i < 13; i = i + 1) begin
        if (sh[16:13] > 4'h4) sh[16:13] = sh[16:13] + 4'h3;
        if (sh[20:17] > 4'h4) sh[20:17] = sh[20:17] + 4'h3;
        if (sh[24:21] > 4'h4) sh[24:21] = sh[24:21] + 4'h3;
        if (sh[28:25] > 4'h4) sh[28:25] = sh[28:25] + 4'h3;
        sh = {sh[27:0], 1'b0};
      end
      to_bcd = sh[28:13];
    end
  endfunction

  // reset release and pin synchronisers
  reg        rst_q1, rst_q2;
  reg        kd_q1, kd_q2, kd_q3;
  reg [3:0]  kc_q1, kc_q2;
  reg        le_q1, le_q2, pa_q1, pa_q2, pa_q3, pb_q1, pb_q2, pb_q3;
  wire       rst_n = rst_q2;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {kd_q1, kd_q2, kd_q3, le_q1, le_q2} <= 5'h00;
      {pa_q1, pa_q2, pa_q3, pb_q1, pb_q2, pb_q3} <= 6'h00;
      kc_q1 <= 4'h0;
      kc_q2 <= 4'h0;
    end else begin
      {kd_q1, kd_q2, kd_q3} <= {key_down, kd_q1, kd_q2};
      kc_q1 <= key_code;
      kc_q2 <= kc_q1;
      {le_q1, le_q2} <= {log_enable, le_q1};
      {pa_q1, pa_q2, pa_q3} <= {pulse_a, pa_q1, pa_q2};
      {pb_q1, pb_q2, pb_q3} <= {pulse_b, pb_q1, pb_q2};
    end
  end

  wire       press = kd_q2 & ~kd_q3;
  wire       is_digit = (kc_q2 <= 4'h9);

  // keypad interpreter state
  reg [1:0]  ui_q;
  reg [3:0]  mode_num_q;
  reg        tbl_on_q;
  reg [3:0]  ptr_ch_q;
  reg [1:0]  ptr_ent_q;
  reg [13:0] ent_mag_q;
  reg [2:0]  ent_frac_q, ent_sig_q;
  reg        ent_dp_q, ent_neg_q, ent_any_q;
  reg        mon_sel_q, mon_kick_q;
  reg [3:0]  mon_ch_q;
  reg [7:0]  prog_q [1:9];
  reg signed [31:0] mult_q [1:9];
  reg signed [31:0] offs_q [1:9];
  integer k;

  wire [31:0] ent_abs = {18'h00000, ent_mag_q} * pow10(3'h4 - ent_frac_q);
  wire signed [31:0] ent_val = ent_neg_q ? -$signed(ent_abs) : $signed(ent_abs);
  wire        ent_ch_ok = ent_any_q && !ent_dp_q && (ent_mag_q <= 14'h0009);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ui_q <= U_PROMPT;
      mode_num_q <= 4'h0;
      tbl_on_q <= 1'b0;
      ptr_ch_q <= `KITE_CH_FIRST;
      ptr_ent_q <= `KITE_ENT_PROG;
      {ent_mag_q, ent_frac_q, ent_sig_q} <= 20'h00000;
      {ent_dp_q, ent_neg_q, ent_any_q} <= 3'h0;
      {mon_sel_q, mon_kick_q} <= 2'h0;
      mon_ch_q <= 4'h0;
      for (k = 1; k <= 9; k = k + 1) begin
        prog_q[k] <= 8'h00;
        mult_q[k] <= `KITE_MULT_RST;
        offs_q[k] <= `KITE_ZERO32;
      end
    end else begin
      mon_kick_q <= 1'b0;
      if (press) begin
        if (is_digit) begin
          if (ui_q == U_PROMPT) begin
            mode_num_q <= kc_q2;
            tbl_on_q <= 1'b0;
            mon_sel_q <= 1'b0;
            if (kc_q2 == `KITE_MODE_TABLE)
              ui_q <= U_TABLE;
            else if (kc_q2 == `KITE_MODE_MON)
              ui_q <= U_MON;
            else
              ui_q <= U_OTHER;
          end else if (ui_q == U_MON && mon_sel_q) begin
            mon_ch_q <= kc_q2;
            mon_kick_q <= 1'b1;
          end else if (ui_q != U_OTHER) begin
            ent_any_q <= 1'b1;
            // leading zeros are not significant and do not use up a digit
            if (ent_sig_q < `KITE_MULT_DIGITS && (!ent_dp_q || ent_frac_q < 3'h4)) begin
              ent_mag_q <= ent_mag_q * 14'd10 + {10'h000, kc_q2};
              if (ent_mag_q != 14'h0000 || kc_q2 != 4'h0)
                ent_sig_q <= ent_sig_q + 3'h1;
              if (ent_dp_q)
                ent_frac_q <= ent_frac_q + 3'h1;
            end
          end
        end else begin
          case (kc_q2)
            `KITE_KEY_STAR: begin
              ui_q <= U_PROMPT;
              mon_sel_q <= 1'b0;
            end
            `KITE_KEY_ADV: begin
              if (ui_q == U_TABLE) begin
                if (!tbl_on_q) begin
                  tbl_on_q <= 1'b1;
                  ptr_ent_q <= `KITE_ENT_PROG;
                  if (ent_ch_ok && ent_mag_q != 14'h0000)
                    ptr_ch_q <= ent_mag_q[3:0];
                  else
                    ptr_ch_q <= `KITE_CH_FIRST;
                end else begin
                  if (ent_any_q) begin
                    case (ptr_ent_q)
                      `KITE_ENT_PROG: prog_q[ptr_ch_q] <= ent_mag_q[7:0];
                      `KITE_ENT_MULT: mult_q[ptr_ch_q] <= ent_val;
                      default:        offs_q[ptr_ch_q] <= ent_val;
                    endcase
                  end
                  if (ptr_ent_q == `KITE_ENT_OFFS) begin
                    ptr_ent_q <= `KITE_ENT_PROG;
                    ptr_ch_q <= (ptr_ch_q == `KITE_CH_LAST) ? `KITE_CH_FIRST
                                                           : ptr_ch_q + 4'h1;
                  end else begin
                    ptr_ent_q <= ptr_ent_q + 2'h1;
                  end
                end
              end else if (ui_q == U_MON && ent_ch_ok) begin
                mon_ch_q <= ent_mag_q[3:0];
                mon_sel_q <= 1'b1;
                mon_kick_q <= 1'b1;
              end
            end
            `KITE_KEY_REST: begin
              if (ui_q == U_TABLE) begin
                tbl_on_q <= 1'b1;
                ptr_ch_q <= `KITE_CH_FIRST;
                ptr_ent_q <= `KITE_ENT_PROG;
              end else if (ui_q == U_MON) begin
                mon_sel_q <= 1'b0;
              end
            end
            `KITE_KEY_NEG: ent_neg_q <= ~ent_neg_q;
            `KITE_KEY_DP:  ent_dp_q <= 1'b1;
            default: ;
          endcase
          if (kc_q2 != `KITE_KEY_NEG && kc_q2 != `KITE_KEY_DP) begin
            {ent_mag_q, ent_frac_q, ent_sig_q} <= 20'h00000;
            {ent_dp_q, ent_neg_q, ent_any_q} <= 3'h0;
          end
        end
        if (is_digit && ui_q == U_PROMPT) begin
          {ent_mag_q, ent_frac_q, ent_sig_q} <= 20'h00000;
          {ent_dp_q, ent_neg_q, ent_any_q} <= 3'h0;
        end
      end
    end
  end

  // scan timer, pulse counters and measurement sequencer
  reg [31:0] scan_tmr_q, mon_tmr_q;
  reg        scan_pend_q, scan_act_q, scan_clr_q, mon_pend_q, mon_have_q, mon_busy_q;
  reg [3:0]  scan_ch_q;
  reg [1:0]  sq_q;
  reg [11:0] cnt_a_q;
  reg [3:0]  cnt_b_q;
  reg signed [31:0] read_q [1:9];
  reg signed [31:0] mon_val_q;
  integer j;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_a_q <= 12'h000;
      cnt_b_q <= 4'h0;
    end else if (scan_clr_q) begin
      cnt_a_q <= 12'h000;
      cnt_b_q <= 4'h0;
    end else begin
      if (pa_q2 && !pa_q3 && cnt_a_q != `KITE_CNT_A_MAX)
        cnt_a_q <= cnt_a_q + 12'h001;
      if (pb_q2 && !pb_q3 && cnt_b_q != `KITE_CNT_B_MAX)
        cnt_b_q <= cnt_b_q + 4'h1;
    end
  end

  wire [3:0]  cur_ch = scan_act_q ? scan_ch_q : mon_ch_q;
  wire [7:0]  cur_prog = (cur_ch == `KITE_CH_BATT) ? 8'h00 : prog_q[cur_ch];
  wire        cur_pulse = (cur_ch == `KITE_CH_PULSE_A) || (cur_ch == `KITE_CH_PULSE_B);
  wire [31:0] cnt_raw = (cur_ch == `KITE_CH_PULSE_A) ? {20'h00000, cnt_a_q}
                                                     : {28'h0000000, cnt_b_q};
  wire signed [31:0] raw_now = cur_pulse ? $signed(cnt_raw * 32'd10000)
                                         : $signed(meas_raw_input_units);
  wire signed [31:0] eu_now = (cur_ch == `KITE_CH_BATT) ? raw_now
                            : scale(mult_q[cur_ch], offs_q[cur_ch], raw_now);
  wire        unused_ch = (cur_ch != `KITE_CH_BATT) && (cur_prog == 8'h00);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scan_tmr_q <= 32'h0000_0000;
      mon_tmr_q <= 32'h0000_0000;
      {scan_pend_q, scan_act_q, scan_clr_q, scan_done_q} <= 4'h0;
      {mon_pend_q, mon_have_q, mon_busy_q, meas_req_q} <= 4'h0;
      scan_ch_q <= `KITE_CH_FIRST;
      sq_q <= S_IDLE;
      meas_chan_q <= 4'h0;
      meas_prog_q <= 8'h00;
      mon_val_q <= `KITE_ZERO32;
      for (j = 1; j <= 9; j = j + 1)
        read_q[j] <= `KITE_ZERO32;
    end else begin
      {scan_clr_q, scan_done_q, meas_req_q} <= 3'h0;
      if (scan_tmr_q >= SCAN_CYCLES - 32'h1) begin
        scan_tmr_q <= 32'h0000_0000;
        if (le_q2)
          scan_pend_q <= 1'b1;
      end else begin
        scan_tmr_q <= scan_tmr_q + 32'h1;
      end
      if (mon_kick_q) begin
        mon_have_q <= 1'b0;
        mon_pend_q <= 1'b1;
        mon_tmr_q <= 32'h0000_0000;
      end else if (mon_sel_q && ui_q == U_MON) begin
        if (mon_tmr_q >= MON_CYCLES - 32'h1) begin
          mon_tmr_q <= 32'h0000_0000;
          mon_pend_q <= 1'b1;
        end else begin
          mon_tmr_q <= mon_tmr_q + 32'h1;
        end
      end
      case (sq_q)
        S_IDLE: begin
          if (scan_act_q) begin
            if (unused_ch || cur_pulse) begin
              read_q[scan_ch_q] <= unused_ch ? `KITE_ZERO32 : eu_now;
              if (scan_ch_q == `KITE_CH_LAST) begin
                scan_act_q <= 1'b0;
                scan_clr_q <= 1'b1;
                scan_done_q <= 1'b1;
              end else begin
                scan_ch_q <= scan_ch_q + 4'h1;
              end
            end else begin
              meas_req_q <= 1'b1;
              meas_chan_q <= scan_ch_q;
              meas_prog_q <= cur_prog;
              sq_q <= S_WAIT;
            end
          end else if (scan_pend_q) begin
            scan_pend_q <= 1'b0;
            scan_act_q <= 1'b1;
            scan_ch_q <= `KITE_CH_FIRST;
          end else if (mon_pend_q && !mon_kick_q) begin
            mon_pend_q <= 1'b0;
            if (unused_ch || cur_pulse) begin
              mon_val_q <= unused_ch ? `KITE_ZERO32 : eu_now;
              mon_have_q <= 1'b1;
            end else begin
              meas_req_q <= 1'b1;
              meas_chan_q <= mon_ch_q;
              meas_prog_q <= cur_prog;
              mon_busy_q <= 1'b1;
              sq_q <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          if (meas_valid) begin
            sq_q <= S_IDLE;
            if (mon_busy_q) begin
              mon_busy_q <= 1'b0;
              // a result for a channel abandoned mid-flight is dropped
              if (!mon_kick_q && !mon_pend_q) begin
                mon_val_q <= eu_now;
                mon_have_q <= 1'b1;
              end
            end else begin
              read_q[scan_ch_q] <= eu_now;
              if (scan_ch_q == `KITE_CH_LAST) begin
                scan_act_q <= 1'b0;
                scan_clr_q <= 1'b1;
                scan_done_q <= 1'b1;
              end else begin
                scan_ch_q <= scan_ch_q + 4'h1;
              end
            end
          end
        end
        default: sq_q <= S_IDLE;
      endcase
    end
  end

  // display selection and formatting
  reg [7:0]  sel_id;
  reg        sel_blank;
  reg signed [31:0] sel_val;
  reg [31:0] mag;
  reg [12:0] n;
  reg [31:0] quo;
  reg [1:0]  pt;

  always @* begin
    sel_id = 8'h00;
    sel_blank = 1'b0;
    sel_val = `KITE_ZERO32;
    case (ui_q)
      U_PROMPT: sel_id = 8'h00;
      U_OTHER: begin
        sel_id = {4'h0, mode_num_q};
        sel_blank = 1'b1;
      end
      U_TABLE: begin
        sel_id = tbl_on_q ? {ptr_ch_q, 2'b00, ptr_ent_q} : {4'h0, mode_num_q};
        sel_blank = !tbl_on_q && !ent_any_q;
        if (ent_any_q)
          sel_val = ent_val;
        else if (ptr_ent_q == `KITE_ENT_PROG)
          sel_val = $signed({24'h000000, prog_q[ptr_ch_q]} * 32'd10000);
        else if (ptr_ent_q == `KITE_ENT_MULT)
          sel_val = mult_q[ptr_ch_q];
        else
          sel_val = offs_q[ptr_ch_q];
      end
      default: begin
        sel_id = mon_sel_q ? {4'h0, mon_ch_q} : {4'h0, mode_num_q};
        sel_blank = !(mon_sel_q && mon_have_q) && !ent_any_q;
        sel_val = (mon_sel_q && mon_have_q) ? mon_val_q : ent_val;
      end
    endcase
    mag = sel_val[31] ? $unsigned(-sel_val) : $unsigned(sel_val);
    // at most three decimals shown; drop a digit rather than show 7000-9999
    if (mag / 32'd10 <= `KITE_DISP_MAX) begin
      quo = mag / 32'd10;
      pt = 2'h3;
    end else if (mag / 32'd100 <= `KITE_DISP_MAX) begin
      quo = mag / 32'd100;
      pt = 2'h2;
    end else if (mag / 32'd1000 <= `KITE_DISP_MAX) begin
      quo = mag / 32'd1000;
      pt = 2'h1;
    end else if (mag / 32'd10000 <= `KITE_DISP_MAX) begin
      quo = mag / 32'd10000;
      pt = 2'h0;
    end else begin
      quo = `KITE_DISP_MAX;
      pt = 2'h0;
    end
    n = quo[12:0];
    if (ui_q == U_PROMPT)
      pt = 2'h0;
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      disp_id_q <= 8'h00;
      disp_data_q <= 16'h0000;
      disp_point_q <= 2'h0;
      {disp_neg_q, disp_blank_q, disp_colon_q} <= 3'b001;
    end else begin
      disp_id_q <= sel_id;
      disp_data_q <= to_bcd(n);
      disp_point_q <= pt;
      disp_neg_q <= sel_val[31] && (n != 13'd0);
      disp_blank_q <= sel_blank;
      disp_colon_q <= 1'b1;
    end
  end

endmodule

// ---- kite_fe_model.sv ----
`timescale 1ns/1ps
module kite_fe_model (
  // clock and reset
  input  logic        clock,
  input  logic        reset_n,
  // request from the logger
  input  logic        meas_req_q,
  // bench controls: reading and answer delay
  input  logic [31:0] raw_val,
  input  logic [7:0]  dly,
  // answer
  output logic        meas_valid,
  output logic [31:0] meas_raw_input_units
);
  logic       busy_q;
  logic [7:0] cnt_q;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      meas_valid <= 1'b0;
      meas_raw_input_units <= 32'h0000_0000;
    end else begin
      meas_valid <= 1'b0;
      // outside a result the bus toggles so nothing stale can pass for data
      meas_raw_input_units <= ~meas_raw_input_units;
      if (meas_req_q) begin
        busy_q <= 1'b1;
        cnt_q <= dly;
      end else if (busy_q && cnt_q == 8'h00) begin
        busy_q <= 1'b0;
        meas_valid <= 1'b1;
        meas_raw_input_units <= raw_val;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        key_down = 1'b0;
  logic [3:0]  key_code = 4'h0;
  logic        log_enable = 1'b0;
  logic        pulse_a = 1'b0;
  logic        pulse_b = 1'b0;
  logic [31:0] raw_val = 32'h0;
  logic [7:0]  dly = 8'h00;
  wire         meas_req_q, meas_valid, disp_neg_q, disp_blank_q, disp_colon_q, scan_done_q;
  wire  [3:0]  meas_chan_q;
  wire  [7:0]  meas_prog_q, disp_id_q;
  wire  [31:0] meas_raw_input_units;
  wire  [15:0] disp_data_q;
  wire  [1:0]  disp_point_q;
  integer      miscompares = 0, n_compared = 0, cyc = 0, seed, c, e, i, r;
  logic [55:0] exp_q[$];
  logic [55:0] n;
  event        look;
  localparam [27:0] MID = 28'hff80000, MNP = 28'hffcffff, MALL = 28'hfffffff;

  kite_core #(.SCAN_CYCLES(32'd2000), .MON_CYCLES(32'd200)) uut (.clock(clock),
    .reset_n(reset_n), .key_down(key_down), .key_code(key_code), .log_enable(log_enable),
    .pulse_a(pulse_a), .pulse_b(pulse_b), .meas_req_q(meas_req_q), .meas_chan_q(meas_chan_q),
    .meas_prog_q(meas_prog_q), .meas_valid(meas_valid),
    .meas_raw_input_units(meas_raw_input_units), .disp_id_q(disp_id_q),
    .disp_data_q(disp_data_q), .disp_point_q(disp_point_q), .disp_neg_q(disp_neg_q),
    .disp_blank_q(disp_blank_q), .disp_colon_q(disp_colon_q), .scan_done_q(scan_done_q));
  kite_fe_model u_fe (.clock(clock), .reset_n(reset_n), .meas_req_q(meas_req_q),
    .raw_val(raw_val), .dly(dly), .meas_valid(meas_valid),
    .meas_raw_input_units(meas_raw_input_units));

  always #12.5 clock = ~clock;

  // largest point position that keeps the shown magnitude at or under 6999
  function automatic [18:0] fmt(input integer v);
    integer a, q, p;
    a = (v < 0) ? -v : v;
    fmt = {v < 0, 2'd0, 16'h6999};
    for (p = 0; p < 4; p++) begin
      q = a / (10 ** (4 - p));
      if (q <= 6999)
        fmt = {v < 0, p[1:0], 4'(q / 1000), 4'(q / 100 % 10), 4'(q / 10 % 10), 4'(q % 10)};
    end
  endfunction

  task cmp(input [27:0] got, input [27:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t display got %h expected %h", $time, got, exp);
    end
  endtask

  task summarize;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // one press, released long enough for the synchronizer to see a gap
  task key(input [3:0] k);
    key_down = 1'b1;
    key_code = k;
    repeat (5) @(posedge clock);
    #1 key_down = 1'b0;
    repeat (6) @(posedge clock);
    #1;
  endtask

  task keys(input [31:0] s, input integer cnt);
    integer k;
    for (k = cnt - 1; k >= 0; k--) key(s[4*k+:4]);
  endtask

  task chk(input [7:0] id, input [18:0] f, input b, input [27:0] m);
    exp_q.push_back({m, b, id, f});
    -> look;
    @(posedge clock);
    #1;
  endtask

  // a monitored value shows blank until the reading lands
  task wv(input [7:0] id, input integer v);
    integer w;
    w = 0;
    while (disp_blank_q !== 1'b0 && w < 1000) begin
      @(posedge clock);
      #1 w++;
    end
    if (w >= 1000) begin
      miscompares++;
      $display("[ERR] %0t display stayed blank", $time);
    end
    chk(id, fmt(v), 1'b0, MALL);
  endtask

  always @(look) begin
    n = exp_q.pop_front();
    cmp({disp_blank_q, disp_id_q, disp_neg_q, disp_point_q, disp_data_q} & n[55:28],
        n[27:0] & n[55:28]);
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    seed = 41099;
    repeat (12) @(posedge clock);
    #1 reset_n = 1'b1;
    repeat (6) @(posedge clock);
    #1 chk(8'h00, fmt(0), 1'b0, MNP);
    keys(32'he4, 2);
    chk(8'h04, 19'h0, 1'b1, MID);
    key(4'ha);
    chk(8'h11, fmt(0), 1'b0, MNP);
    key(4'ha);
    chk(8'h12, fmt(10000), 1'b0, MALL);
    c = 1;
    e = 2;
    repeat (26) begin
      key(4'ha);
      e = e + 1;
      if (e > 3) begin
        e = 1;
        c = (c == 9) ? 1 : c + 1;
      end
      chk({c[3:0], e[3:0]}, 19'h0, 1'b0, MID);
    end
    keys(32'hab, 2);
    chk(8'h11, 19'h0, 1'b0, MID);
    $display("test table walk done");
    keys(32'he46a, 4);
    chk(8'h61, fmt(0), 1'b0, MNP);
    keys(32'h1a, 2);
    chk(8'h62, 19'h0, 1'b0, MID);
    keys(32'h0d0146a, 7);
    keys(32'h2ca, 3);
    chk(8'h71, 19'h0, 1'b0, MID);
    keys(32'he48a1a, 6);
    keys(32'haa1a, 4);
    keys(32'he46aa, 5);
    chk(8'h62, fmt(146), 1'b0, MALL);
    key(4'ha);
    chk(8'h63, fmt(-20000), 1'b0, MALL);
    $display("test table entry done");
    raw_val = 32'd10000000;
    dly = 8'd40;
    keys(32'he66a, 4);
    wv(8'h06, 126000);
    r = $random(seed) % 69990000;
    r = (r < 0) ? -r : r;
    raw_val = r;
    dly = $random(seed) & 8'h0f;
    key(4'h0);
    wv(8'h00, r);
    $display("test monitor done");
    for (i = 0; i < 4100; i++) begin
      pulse_a = 1'b1;
      pulse_b = (i < 20);
      repeat (3) @(posedge clock);
      #1 pulse_a = 1'b0;
      pulse_b = 1'b0;
      repeat (3) @(posedge clock);
      #1;
    end
    key(4'h8);
    wv(8'h08, 40950000);
    key(4'h9);
    wv(8'h09, 150000);
    dly = 8'h00;
    log_enable = 1'b1;
    i = 0;
    while (scan_done_q !== 1'b1 && i < 3000) begin
      @(posedge clock);
      #1 i++;
    end
    if (i >= 3000) begin
      miscompares++;
      $display("[ERR] %0t no scan completed", $time);
    end
    repeat (450) @(posedge clock);
    #1 wv(8'h09, 0);
    key(4'he);
    chk(8'h00, fmt(0), 1'b0, MNP);
    $display("test counters done");
    summarize();
  end
endmodule
